// File: design/dual_slope_pwm_timer.sv
// Dual-slope PWM timer top: Wishbone registers, modes, flags and pins.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`default_nettype none
`include "pwm_defs.svh"

////////////////////////////////////////////////////////////////////////////

module dual_slope_pwm_timer
  import pwm_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_tick,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_compare_output_a,
  output logic             o_compare_output_a_drive,
  output logic             o_compare_output_b,
  output logic             o_compare_output_b_drive
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  ctrl_t       ctrl_q;
  flags_t      flags_q;
  flags_t      set_ev;
  flags_t      clr;
  logic [15:0] capture_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [15:0] ctrl_m;
  logic        req;
  logic        wr_en;
  logic        cnt_wr;
  logic [15:0] count;
  logic [15:0] top;
  logic        down;
  logic        dual;
  logic        pfc;
  logic        tick_run;
  logic        at_top;
  logic        at_bottom;
  logic        up_eff;
  logic        load;
  logic        toggle_ok;
  logic        conn_a;
  logic        conn_b;
  logic        match_a;
  logic        match_b;
  logic        wave_a;
  logic        wave_b;
  logic [15:0] cmp_a_act;
  logic [15:0] cmp_a_buf;
  logic [15:0] cmp_b_act;
  logic [15:0] cmp_b_buf;
  logic        pin_a_q;
  logic        pin_b_q;
  logic        drive_a_q;
  logic        drive_b_q;

  // Everything the decode reads is an argument. A continuous assignment re-evaluates
  // only when its operands change, so a hidden module read would leave the strobe stale.
  function automatic logic hit(input logic en, input logic [7:0] adr, input logic [7:0] a);
    return en && (adr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  // A write lands on the edge where the master sees ack, never earlier.
  assign req    = i_wb_cyc && i_wb_stb;
  assign wr_en  = req && i_wb_we && ack_q;
  assign cnt_wr = hit(wr_en, i_wb_adr, `ADR_COUNT);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    case (i_wb_adr)
      `ADR_CTRL:    rdat_d = 32'(ctrl_q);
      `ADR_COUNT:   rdat_d = 32'(count);
      `ADR_CMP_A:   rdat_d = 32'(cmp_a_buf);
      `ADR_CMP_B:   rdat_d = 32'(cmp_b_buf);
      `ADR_CAPTURE: rdat_d = 32'(capture_q);
      `ADR_FLAGS:   rdat_d = 32'(flags_q);
      `ADR_STATUS:  rdat_d = 32'({pfc, dual, down});
      default:      rdat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      rdat_q <= rdat_d;
    end
  end

  assign o_wb_dat = rdat_q;
  assign o_wb_ack = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control and capture registers

  assign ctrl_m = merge16(16'(ctrl_q), i_wb_dat[15:0], i_wb_sel[1:0]);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= '0;
    end else if (hit(wr_en, i_wb_adr, `ADR_CTRL)) begin
      ctrl_q <= ctrl_t'(ctrl_m[9:0]);
    end
  end

  // The capture value has no buffer, so a new TOP acts at once.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      capture_q <= `BOTTOM;
    end else if (hit(wr_en, i_wb_adr, `ADR_CAPTURE)) begin
      capture_q <= merge16(capture_q, i_wb_dat[15:0], i_wb_sel[1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and counter

  assign dual = is_dual(ctrl_q.wave_mode);
  assign pfc  = is_pfc(ctrl_q.wave_mode);
  // Any register TOP from 0x0000 up to the full count is accepted as is.
  assign top  = top_of(ctrl_q.wave_mode, capture_q, cmp_a_act);

  // The prescaler outside supplies i_tick, so one period is 2*N*TOP clocks.
  assign tick_run  = i_tick && dual;
  assign at_top    = (count == top);
  assign at_bottom = (count == `BOTTOM);
  assign load      = tick_run && (pfc ? at_bottom : at_top);

  // Matches at zero count as rising and at TOP as falling, which pins the
  // non-inverting output low for a zero compare and high for a compare equal to TOP.
  assign up_eff = at_bottom || (!at_top && !down);

  dual_slope_counter u_counter (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_tick   (tick_run),
    .i_top    (top),
    .i_wr     (cnt_wr),
    .i_wr_val (merge16(count, i_wb_dat[15:0], i_wb_sel[1:0])),
    .o_count  (count),
    .o_down   (down)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare channels

  assign toggle_ok = (ctrl_q.wave_mode == `MODE_PC_CMPA) ||
                     (ctrl_q.wave_mode == `MODE_PFC_CMPA);

  compare_channel u_cmp_a (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_buffered  (dual),
    .i_fixed_top (top_is_fixed(ctrl_q.wave_mode)),
    .i_top       (top),
    .i_wr        (hit(wr_en, i_wb_adr, `ADR_CMP_A)),
    .i_wdat      (i_wb_dat[15:0]),
    .i_sel       (i_wb_sel[1:0]),
    .i_load      (load),
    .i_tick      (tick_run),
    .i_count     (count),
    .i_up        (up_eff),
    .i_mode      (ctrl_q.out_a_mode),
    .i_toggle_ok (toggle_ok),
    .o_active    (cmp_a_act),
    .o_buffer    (cmp_a_buf),
    .o_match     (match_a),
    .o_wave      (wave_a)
  );

  // Channel B never toggles; its toggle code leaves the pin disconnected.
  compare_channel u_cmp_b (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_buffered  (dual),
    .i_fixed_top (top_is_fixed(ctrl_q.wave_mode)),
    .i_top       (top),
    .i_wr        (hit(wr_en, i_wb_adr, `ADR_CMP_B)),
    .i_wdat      (i_wb_dat[15:0]),
    .i_sel       (i_wb_sel[1:0]),
    .i_load      (load),
    .i_tick      (tick_run),
    .i_count     (count),
    .i_up        (up_eff),
    .i_mode      (ctrl_q.out_b_mode),
    .i_toggle_ok (1'b0),
    .o_active    (cmp_b_act),
    .o_buffer    (cmp_b_buf),
    .o_match     (match_b),
    .o_wave      (wave_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event flags

  assign set_ev.ovf   = tick_run && at_bottom;
  assign set_ev.cmp_a = match_a;
  assign set_ev.cmp_b = match_b;
  assign set_ev.capt  = tick_run && at_top && ((ctrl_q.wave_mode == `MODE_PC_CAPT) ||
                        (ctrl_q.wave_mode == `MODE_PFC_CAPT));

  assign clr = (hit(wr_en, i_wb_adr, `ADR_FLAGS) && i_wb_sel[0]) ? flags_t'(i_wb_dat[3:0]) : '0;

  // A flag raised in the same cycle as its clear survives.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~clr) | set_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins

  assign conn_a = (ctrl_q.out_a_mode == `OUT_NONINV) || (ctrl_q.out_a_mode == `OUT_INV) ||
                  ((ctrl_q.out_a_mode == `OUT_TOGGLE) && toggle_ok);
  assign conn_b = (ctrl_q.out_b_mode == `OUT_NONINV) || (ctrl_q.out_b_mode == `OUT_INV);

  // Pins lag the waveform bit by one clock, identical for both channels.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drive_a_q <= 1'b0;
      drive_b_q <= 1'b0;
    end else begin
      drive_a_q <= ctrl_q.dir_a && conn_a;
      drive_b_q <= ctrl_q.dir_b && conn_b;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
    end else begin
      pin_a_q <= wave_a && ctrl_q.dir_a && conn_a;
      pin_b_q <= wave_b && ctrl_q.dir_b && conn_b;
    end
  end

  assign o_compare_output_a       = pin_a_q;
  assign o_compare_output_a_drive = drive_a_q;
  assign o_compare_output_b       = pin_b_q;
  assign o_compare_output_b_drive = drive_b_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  count_step_a: assert property (
    tick_run && !cnt_wr && !at_bottom && count < top
    |=> count == ($past(down) ? $past(count) - `STEP : $past(count) + `STEP))
    else $error("Counter did not step by one between zero and TOP.");

  top_turn_a: assert property (
    tick_run && !cnt_wr && at_top && !at_bottom
    |=> down && count == $past(count) - `STEP)
    else $error("Counter did not leave TOP downward after one tick.");

  fixed_top_a: assert property (
    ctrl_q.wave_mode == `MODE_PC_9B ##1 ctrl_q.wave_mode == `MODE_PC_9B
    |-> top == `TOP_9B && dual && !pfc)
    else $error("Nine-bit phase correct mode has the wrong TOP.");

  bottom_flag_a: assert property (
    tick_run && at_bottom |=> flags_q.ovf)
    else $error("Overflow flag not set at zero.");

  match_flag_a: assert property (
    match_b |=> flags_q.cmp_b)
    else $error("Compare B flag not set on a match.");

  match_a_flag_a: assert property (
    match_a |=> flags_q.cmp_a)
    else $error("Compare A flag not set on a match.");

  pfc_capt_a: assert property (
    tick_run && at_top && ctrl_q.wave_mode == `MODE_PFC_CAPT |=> flags_q.capt)
    else $error("Capture flag not set at TOP in frequency correct mode.");

  ack_pulse_a: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("Bus acknowledge lasted more than one cycle.");

  capt_top_a: assert property (
    tick_run && at_top && ctrl_q.wave_mode == `MODE_PC_CAPT |=> flags_q.capt)
    else $error("Capture flag not set at a capture-defined TOP.");

  pc_load_a: assert property (
    tick_run && at_top && !pfc |=> cmp_a_act == $past(cmp_a_buf))
    else $error("Phase correct mode did not load compare A at TOP.");

  pfc_load_a: assert property (
    tick_run && at_bottom && pfc |=> cmp_b_act == $past(cmp_b_buf) && flags_q.ovf)
    else $error("Frequency correct mode did not load and flag at zero.");

  pin_gate_a: assert property (
    !ctrl_q.dir_a |=> !o_compare_output_a && !o_compare_output_a_drive)
    else $error("Pin A driven while its direction bit is clear.");

endmodule // dual_slope_pwm_timer
`default_nettype wire

// File: design/pwm_defs.svh
// Register offsets, mode codes and fixed values of the dual-slope PWM timer.
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

`define ADR_CTRL      8'h00
`define ADR_COUNT     8'h04
`define ADR_CMP_A     8'h08
`define ADR_CMP_B     8'h0c
`define ADR_CAPTURE   8'h10
`define ADR_FLAGS     8'h14
`define ADR_STATUS    8'h18

`define MODE_PC_8B    4'h1
`define MODE_PC_9B    4'h2
`define MODE_PC_10B   4'h3
`define MODE_PC_CAPT  4'ha
`define MODE_PC_CMPA  4'hb
`define MODE_PFC_CAPT 4'h8
`define MODE_PFC_CMPA 4'h9

`define OUT_OFF       2'h0
`define OUT_TOGGLE    2'h1
`define OUT_NONINV    2'h2
`define OUT_INV       2'h3

`define TOP_8B        16'h00ff
`define TOP_9B        16'h01ff
`define TOP_10B       16'h03ff
`define COUNT_MAX     16'hffff
`define BOTTOM        16'h0000
`define STEP          16'h0001

`endif

// File: design/pwm_pkg.sv
// Types and shared helper functions of the dual-slope PWM timer.
`default_nettype none
`include "pwm_defs.svh"

package pwm_pkg;

  typedef struct packed {
    logic       dir_b;
    logic       dir_a;
    logic [1:0] out_b_mode;
    logic [1:0] out_a_mode;
    logic [3:0] wave_mode;
  } ctrl_t;

  typedef struct packed {
    logic capt;
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } flags_t;

  function automatic logic is_pfc(input logic [3:0] m);
    return (m == `MODE_PFC_CAPT) || (m == `MODE_PFC_CMPA);
  endfunction

  function automatic logic top_is_fixed(input logic [3:0] m);
    return (m == `MODE_PC_8B) || (m == `MODE_PC_9B) || (m == `MODE_PC_10B);
  endfunction

  function automatic logic is_dual(input logic [3:0] m);
    return is_pfc(m) || top_is_fixed(m) || (m == `MODE_PC_CAPT) || (m == `MODE_PC_CMPA);
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] capt,
                                         input logic [15:0] cmpa);
    case (m)
      `MODE_PC_8B:                   return `TOP_8B;
      `MODE_PC_9B:                   return `TOP_9B;
      `MODE_PC_10B:                  return `TOP_10B;
      `MODE_PC_CAPT, `MODE_PFC_CAPT: return capt;
      `MODE_PC_CMPA, `MODE_PFC_CMPA: return cmpa;
      default:                       return `COUNT_MAX;
    endcase
  endfunction

  // Byte-lane merge of a 16-bit register under the two low Wishbone selects.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] sel);
    return {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

endpackage
`default_nettype wire

// File: design/dual_slope_counter.sv
// Up/down counter that turns round at TOP and at zero.
`default_nettype none
`include "pwm_defs.svh"

module dual_slope_counter (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_tick,
  input  wire logic [15:0] i_top,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wr_val,
  output logic      [15:0] o_count,
  output logic             o_down
);

  logic [15:0] count_q;
  logic        down_q;
  logic        go_down;

  // Past TOP also turns down, so a lowered TOP never lets the count run away.
  assign go_down = ((count_q >= i_top) || down_q) && (count_q != `BOTTOM);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_q <= `BOTTOM;
    end else if (i_wr) begin
      count_q <= i_wr_val;
    end else if (i_tick) begin
      count_q <= go_down ? count_q - `STEP : count_q + `STEP;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      down_q <= 1'b0;
    end else if (i_tick && !i_wr) begin
      down_q <= go_down;
    end
  end

  assign o_count = count_q;
  assign o_down  = down_q;

endmodule // dual_slope_counter
`default_nettype wire

// File: design/compare_channel.sv
// One compare channel: buffered compare value, match and waveform bit.
`default_nettype none
`include "pwm_defs.svh"

module compare_channel
  import pwm_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_buffered,
  input  wire logic        i_fixed_top,
  input  wire logic [15:0] i_top,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wdat,
  input  wire logic [1:0]  i_sel,
  input  wire logic        i_load,
  input  wire logic        i_tick,
  input  wire logic [15:0] i_count,
  input  wire logic        i_up,
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_toggle_ok,
  output logic      [15:0] o_active,
  output logic      [15:0] o_buffer,
  output logic             o_match,
  output logic             o_wave
);

  logic [15:0] buffer_q;
  logic [15:0] active_q;
  logic [15:0] masked;
  logic        wave_q;

  assign masked = i_fixed_top ? (merge16(buffer_q, i_wdat, i_sel) & i_top) :
                  merge16(buffer_q, i_wdat, i_sel);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      buffer_q <= `BOTTOM;
    end else if (i_wr) begin
      buffer_q <= masked;
    end
  end

  // Outside the dual-slope modes a write reaches the compare value at once.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      active_q <= `BOTTOM;
    end else if (i_wr && !i_buffered) begin
      active_q <= masked;
    end else if (i_load) begin
      active_q <= buffer_q;
    end
  end

  assign o_match = i_tick && (i_count == active_q);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wave_q <= 1'b0;
    end else if (o_match) begin
      case (i_mode)
        `OUT_TOGGLE: if (i_toggle_ok) wave_q <= ~wave_q;
        `OUT_NONINV: wave_q <= ~i_up;
        `OUT_INV:    wave_q <= i_up;
        default:     wave_q <= wave_q;
      endcase
    end
  end

  assign o_active = active_q;
  assign o_buffer = buffer_q;
  assign o_wave   = wave_q;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  write_mask_a: assert property (
    i_wr && i_fixed_top |=> (buffer_q & ~$past(i_top)) == `BOTTOM)
    else $error("Compare bits above the fixed resolution were kept.");

  noninv_edge_a: assert property (
    o_match && i_mode == `OUT_NONINV |=> wave_q == !$past(i_up))
    else $error("Non-inverting output took the wrong level on a match.");

  toggle_half_a: assert property (
    o_match && i_mode == `OUT_TOGGLE && i_toggle_ok |=> wave_q != $past(wave_q))
    else $error("Toggle output did not toggle on a match.");

endmodule // compare_channel
`default_nettype wire

// File: bench/pwm_load.sv
// Load on one timer waveform pin, resolving the pin level with a pull-down.
`default_nettype none

module pwm_load (
  input  wire logic i_level,
  input  wire logic i_drive,
  output logic      o_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // An undriven pin is pulled low, so a stale level can never be mistaken for output.
  assign o_pin = i_drive ? i_level : 1'b0;
endmodule // pwm_load

`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench of the dual-slope PWM timer against a behavioural model.
`default_nettype none
`include "pwm_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [3:0]  m;
    logic [1:0]  oa, ob, dir;
    logic [15:0] ca, cb, cp;
  } scen_t;

  logic        clk, rst_b, tick, cyc, stb, we, ack, pa, pad, pb, pbd, pin_a, pin_b;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd, rs;
  logic [3:0]  sel;
  int          err_total, comparisons, m_cnt, m_down;
  logic [3:0]  m_mode, m_flg;
  logic [1:0]  m_om[2];
  logic [1:0]  m_dir;
  logic [15:0] m_act[2], m_buf[2], m_cap, nv;
  logic        m_wave[2];
  scen_t       tbl[8];

  dual_slope_pwm_timer u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_tick(tick), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_compare_output_a(pa),
    .o_compare_output_a_drive(pad), .o_compare_output_b(pb),
    .o_compare_output_b_drive(pbd));
  pwm_load u_load_a (.i_level(pa), .i_drive(pad), .o_pin(pin_a));
  pwm_load u_load_b (.i_level(pb), .i_drive(pbd), .o_pin(pin_b));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic fixd();
    return m_mode inside {4'h1, 4'h2, 4'h3};
  endfunction

  function automatic logic pfc();
    return m_mode inside {4'h8, 4'h9};
  endfunction

  function automatic logic dual();
    return fixd() || pfc() || m_mode inside {4'ha, 4'hb};
  endfunction

  function automatic logic [15:0] top_m();
    case (m_mode)
      4'h1:       return 16'h00ff;
      4'h2:       return 16'h01ff;
      4'h3:       return 16'h03ff;
      4'h8, 4'ha: return m_cap;
      4'h9, 4'hb: return m_act[0];
      default:    return 16'hffff;
    endcase
  endfunction

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      err_total++;
      $display("[FAIL] wb_ack expected 1 seen timeout");
    end
  endtask

  // One timer step of the model; matches use the active values before any reload.
  task automatic m_tick();
    logic [15:0] t;
    int c;
    logic up;
    t = top_m();
    c = m_cnt;
    if (!dual()) return;
    up = (c == 0) || (c != t && m_down == 0);
    for (int i = 0; i < 2; i++) begin
      if (c == m_act[i]) begin
        m_flg[i+1] = 1'b1;
        if (m_om[i] == `OUT_NONINV) m_wave[i] = !up;
        else if (m_om[i] == `OUT_INV) m_wave[i] = up;
        else if (m_om[i] == `OUT_TOGGLE && i == 0) m_wave[i] = !m_wave[i];
      end
    end
    if (c == 0) m_flg[0] = 1'b1;
    if (c == t && m_mode inside {4'h8, 4'ha}) m_flg[3] = 1'b1;
    if ((pfc() && c == 0) || (!pfc() && c == t)) m_act = m_buf;
    if (c == t) begin
      m_down = 1;
      m_cnt = c - 1;
    end else if (c == 0) begin
      m_down = 0;
      m_cnt = 1;
    end else m_cnt = (m_down != 0) ? c - 1 : c + 1;
  endtask

  task automatic burst(input int n);
    logic b;
    repeat (n) begin
      b = (xs() & 32'h3) != 32'h0;
      tick <= b;
      if (b) m_tick();
      @(posedge clk);
    end
    tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic check_all();
    logic cn;
    logic dv;
    wb(1'b0, `ADR_COUNT, 32'h0, 4'hf);
    chk_reg("count", 32'(m_cnt), rd);
    wb(1'b0, `ADR_FLAGS, 32'h0, 4'hf);
    chk_reg("flags", {28'h0, m_flg}, rd);
    wb(1'b0, `ADR_STATUS, 32'h0, 4'hf);
    chk_reg("status", {29'h0, pfc(), dual(), m_down != 0}, rd);
    for (int i = 0; i < 2; i++) begin
      cn = m_om[i] != `OUT_OFF && (m_om[i] != `OUT_TOGGLE || (i == 0 && m_mode inside {4'h9, 4'hb}));
      dv = m_dir[i] & cn;
      chk_pin("drive", dv, (i == 0) ? pad : pbd);
      chk_pin("pin", dv & m_wave[i], (i == 0) ? pin_a : pin_b);
    end
    wb(1'b1, `ADR_FLAGS, 32'hf, 4'hf);
    m_flg = 4'h0;
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    tick <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    m_cnt = 0;
    m_down = 0;
    m_mode = 4'h0;
    m_om = '{2'h0, 2'h0};
    m_dir = 2'h0;
    m_act = '{16'h0, 16'h0};
    m_buf = '{16'h0, 16'h0};
    m_cap = 16'h0;
    m_flg = 4'h0;
    m_wave = '{1'b0, 1'b0};
  endtask

  task automatic final_report();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("[FAIL] watchdog expected done seen timeout");
    final_report();
  end

  initial begin
    rs = 32'h3542;
    err_total = 0;
    comparisons = 0;
    rst_b = 1'b0;
    tick = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    wdat = 32'h0;
    sel = 4'h0;
    tbl[0] = '{`MODE_PC_8B, `OUT_NONINV, `OUT_INV, 2'h3, 16'h0040, 16'h0000, 16'h0000};
    tbl[1] = '{`MODE_PC_9B, `OUT_INV, `OUT_NONINV, 2'h3, 16'h01ff, 16'h0100, 16'h0000};
    tbl[2] = '{`MODE_PC_10B, `OUT_NONINV, `OUT_NONINV, 2'h1, 16'h03ff, 16'h0200, 16'h0};
    tbl[3] = '{`MODE_PC_CAPT, `OUT_NONINV, `OUT_INV, 2'h3, 16'h0001, 16'h0002, 16'h0003};
    tbl[4] = '{`MODE_PC_CMPA, `OUT_TOGGLE, `OUT_NONINV, 2'h3, 16'h0005, 16'h0003, 16'h0};
    tbl[5] = '{`MODE_PFC_CAPT, `OUT_INV, `OUT_TOGGLE, 2'h3, 16'h0004, 16'h0010, 16'h0010};
    tbl[6] = '{`MODE_PFC_CMPA, `OUT_TOGGLE, `OUT_INV, 2'h2, 16'h0007, 16'h0002, 16'h0};
    tbl[7] = '{4'h0, `OUT_OFF, `OUT_NONINV, 2'h3, 16'h0005, 16'h0005, 16'h0000};
    @(posedge clk);
    do_reset();
    wb(1'b0, `ADR_FLAGS, 32'h0, 4'hf);
    chk_reg("flags_rst", 32'h0, rd);
    wb(1'b1, `ADR_CAPTURE, 32'h0000_abcd, 4'h3);
    wb(1'b1, `ADR_CAPTURE, 32'h0000_1234, 4'h2);
    wb(1'b0, `ADR_CAPTURE, 32'h0, 4'hf);
    chk_reg("capture_lane", 32'h0000_12cd, rd);
    wb(1'b1, 8'h1c, 32'hffff_ffff, 4'hf);
    wb(1'b0, 8'h1c, 32'h0, 4'hf);
    chk_reg("unmapped", 32'h0, rd);
    wb(1'b1, `ADR_STATUS, 32'hffff_ffff, 4'hf);
    wb(1'b0, `ADR_STATUS, 32'h0, 4'hf);
    chk_reg("status_ro", 32'h0, rd);
    wb(1'b1, `ADR_COUNT, 32'h0000_0155, 4'h3);
    wb(1'b0, `ADR_COUNT, 32'h0, 4'hf);
    chk_reg("count_write", 32'h0000_0155, rd);
    foreach (tbl[k]) begin
      do_reset();
      wb(1'b1, `ADR_CMP_A, {16'h0, tbl[k].ca}, 4'h3);
      wb(1'b1, `ADR_CMP_B, {16'h0, tbl[k].cb}, 4'h3);
      wb(1'b1, `ADR_CAPTURE, {16'h0, tbl[k].cp}, 4'h3);
      m_act = '{tbl[k].ca, tbl[k].cb};
      m_buf = m_act;
      m_cap = tbl[k].cp;
      wb(1'b1, `ADR_CTRL, {22'h0, tbl[k].dir, tbl[k].ob, tbl[k].oa, tbl[k].m}, 4'h3);
      m_mode = tbl[k].m;
      m_om = '{tbl[k].oa, tbl[k].ob};
      m_dir = tbl[k].dir;
      burst(1500);
      check_all();
      // Upper bits are set on purpose in fixed modes to show that the write is masked.
      nv = top_m() >> 1;
      wb(1'b1, `ADR_CMP_B, {16'h0, fixd() ? (nv | 16'hfc00) : nv}, 4'h3);
      m_buf[1] = nv;
      if (!dual()) m_act[1] = nv;
      wb(1'b0, `ADR_CMP_B, 32'h0, 4'hf);
      chk_reg("cmp_b_buffer", {16'h0, m_buf[1]}, rd);
      repeat (3) begin
        burst(1500);
        check_all();
      end
    end
    final_report();
  end
endmodule // testbench

`default_nettype wire
